//--- hw/alu_slice.sv
// Four-bit processor slice: 16x4 two-port stack, ALU, holding register, shifts.
// Assumes the link interface on one side; a single clock with enable and reset.
`timescale 1ns/1ps
module alu_slice (
    // Link to controller and neighbours
    slice_link_if.device lnk,
    // Clocking
    input wire logic     CLK,
    input wire logic     RESET,
    input wire logic     CE
);

    // Complete state of the slice
    typedef struct packed {
        logic [15:0][3:0] stack;
        logic [3:0]       hold;
    } state_t;

    state_t               s_q;
    state_t               s_d;
    slice_pkg::src_t      src;
    slice_pkg::func_t     func;
    slice_pkg::dest_t     dest;
    logic [3:0]           a_data;
    logic [3:0]           b_data;
    logic [3:0]           r_op;
    logic [3:0]           s_op;
    logic [3:0]           ar;
    logic [3:0]           as;
    logic [4:0]           sum;
    logic [3:0]           low;
    logic [3:0]           gen;
    logic [3:0]           prop;
    logic                 arith;
    logic [3:0]           f;
    logic                 up;
    logic                 down;

    // Instruction field decode
    assign src  = slice_pkg::src_of(lnk.instr);
    assign func = slice_pkg::func_of(lnk.instr);
    assign dest = slice_pkg::dest_of(lnk.instr);
    assign up   = slice_pkg::is_up(lnk.instr);
    assign down = slice_pkg::is_down(lnk.instr);

    // Two read ports; the registered stack only moves on the rising edge
    assign a_data = s_q.stack[lnk.a_sel];
    assign b_data = s_q.stack[lnk.b_sel];

    // Operand source selection
    always_comb begin
        r_op = 4'h0;
        s_op = 4'h0;
        case (src)
            slice_pkg::SRC_AQ: begin
                r_op = a_data;
                s_op = s_q.hold;
            end
            slice_pkg::SRC_AB: begin
                r_op = a_data;
                s_op = b_data;
            end
            slice_pkg::SRC_ZQ: begin
                s_op = s_q.hold;
            end
            slice_pkg::SRC_ZB: begin
                s_op = b_data;
            end
            slice_pkg::SRC_ZA: begin
                s_op = a_data;
            end
            slice_pkg::SRC_DA: begin
                r_op = lnk.d;
                s_op = a_data;
            end
            slice_pkg::SRC_DQ: begin
                r_op = lnk.d;
                s_op = s_q.hold;
            end
            slice_pkg::SRC_DZ: begin
                r_op = lnk.d;
            end
            default: begin
                r_op = 4'h0;
                s_op = 4'h0;
            end
        endcase
    end

    // Adder operands; subtraction inverts one side and uses the carry in
    always_comb begin
        ar    = r_op;
        as    = s_op;
        arith = 1'b1;
        case (func)
            slice_pkg::FN_ADD:  arith = 1'b1;
            slice_pkg::FN_SUBR: ar    = ~r_op;
            slice_pkg::FN_SUBS: as    = ~s_op;
            default:            arith = 1'b0;
        endcase
    end

    // Full sum, sum of the low three bits, per-bit generate and propagate
    assign sum  = {1'b0, ar} + {1'b0, as} + {4'h0, lnk.cin};
    assign low  = {1'b0, ar[2:0]} + {1'b0, as[2:0]} + {3'h0, lnk.cin};
    assign gen  = ar & as;
    assign prop = ar | as;

    // Function result
    always_comb begin
        case (func)
            slice_pkg::FN_ADD,
            slice_pkg::FN_SUBR,
            slice_pkg::FN_SUBS:  f = sum[3:0];
            slice_pkg::FN_OR:    f = r_op | s_op;
            slice_pkg::FN_AND:   f = r_op & s_op;
            slice_pkg::FN_NOTRS: f = ~r_op & s_op;
            slice_pkg::FN_EXOR:  f = r_op ^ s_op;
            slice_pkg::FN_EXNOR: f = ~(r_op ^ s_op);
            default:             f = 4'h0;
        endcase
    end

    // Status flags; logic functions report no carry or overflow
    assign lnk.cout = arith & sum[4];
    assign lnk.overflow_flag  = arith & (sum[4] ^ low[3]);
    assign lnk.g_n  = ~(arith & (gen[3] | (prop[3] & gen[2]) | (prop[3] & prop[2] & gen[1])
                      | (prop[3] & prop[2] & prop[1] & gen[0])));
    assign lnk.p_n  = ~(arith & (&prop));

    // Open-collector zero line pulls low on any set result bit
    assign lnk.zero_o  = 1'b0;
    assign lnk.zero_oe = |f;

    // Result pins: first port data only for the RAMA destination
    assign lnk.y_o  = (dest == slice_pkg::DST_RAMA) ? a_data : f;
    assign lnk.y_oe = ~lnk.oe_n;

    // MSB shift lines drive only on an up shift
    assign lnk.q3_dev_o    = s_q.hold[3];
    assign lnk.q3_dev_oe   = up;
    assign lnk.stack_msb_shift_dev_o  = f[3];
    assign lnk.stack_msb_shift_dev_oe = up;

    // LSB shift lines drive only on a down shift
    assign lnk.q0_dev_o    = s_q.hold[0];
    assign lnk.q0_dev_oe   = down;
    assign lnk.stack_lsb_shift_dev_o  = f[0];
    assign lnk.stack_lsb_shift_dev_oe = down;

    // Next state: destination write-back, shifts, enable and reset
    always_comb begin
        s_d = s_q;
        case (dest)
            slice_pkg::DST_QREG: begin
                s_d.hold = f;
            end
            slice_pkg::DST_NOP: begin
                s_d = s_q;
            end
            slice_pkg::DST_RAMA,
            slice_pkg::DST_RAMF: begin
                s_d.stack[lnk.b_sel] = f;
            end
            slice_pkg::DST_RAMQD: begin
                s_d.stack[lnk.b_sel] = {lnk.stack_msb_shift, f[3:1]};
                s_d.hold             = {lnk.q3, s_q.hold[3:1]};
            end
            slice_pkg::DST_RAMD: begin
                s_d.stack[lnk.b_sel] = {lnk.stack_msb_shift, f[3:1]};
            end
            slice_pkg::DST_RAMQU: begin
                s_d.stack[lnk.b_sel] = {f[2:0], lnk.stack_lsb_shift};
                s_d.hold             = {s_q.hold[2:0], lnk.q0};
            end
            slice_pkg::DST_RAMU: begin
                s_d.stack[lnk.b_sel] = {f[2:0], lnk.stack_lsb_shift};
            end
            default: begin
                s_d = s_q;
            end
        endcase
        if (!CE) begin
            s_d = s_q;
        end
        if (RESET) begin
            s_d.stack = {slice_pkg::DEPTH{slice_pkg::STACK_WORD_RST}};
            s_d.hold  = slice_pkg::HOLD_RST;
        end
    end

    // Single state register, rising edge only
    always_ff @(posedge CLK) begin
        s_q <= s_d;
    end

endmodule

//--- hw/slice_controller.sv
// Far end of the slice link: microinstruction register, neighbour shift bits.
// Assumes the link interface on one side and a user port list on the other.
`timescale 1ns/1ps
module slice_controller (
    // Link to the slice
    slice_link_if.far    lnk,
    // Clocking
    input  wire logic       CLK,
    input  wire logic       RESET,
    input  wire logic       CE,
    // Microinstruction request
    input  wire logic       LOAD,
    input  wire logic [8:0] INSTR,
    input  wire logic [3:0] PORT_ONE_SELECT,
    input  wire logic [3:0] PORT_TWO_SELECT,
    input  wire logic [3:0] DIRECT_OPERAND_IN,
    input  wire logic       CARRY_IN,
    input  wire logic       OUT_EN_N,
    // Neighbour shift bits into the slice
    input  wire logic       HOLDREG_MSB_SHIFT_IN,
    input  wire logic       STACK_MSB_SHIFT_IN,
    input  wire logic       HOLDREG_LSB_SHIFT_IN,
    input  wire logic       STACK_LSB_SHIFT_IN,
    // Captured answer
    output logic [3:0]      RESULT_OUT,
    output logic            CARRY_OUT,
    output logic            OVERFLOW_FLAG,
    output logic            ZERO_FLAG,
    output logic            GEN_N,
    output logic            PROP_N,
    output logic [3:0]      SHIFT_LINES
);

    // Complete state of the controller end
    typedef struct packed {
        logic [8:0] instr;
        logic [3:0] a_sel;
        logic [3:0] b_sel;
        logic [3:0] d;
        logic       cin;
        logic       oe_n;
        logic [3:0] shift_in;
        logic [3:0] result;
        logic       cout;
        logic       overflow_flag;
        logic       zero;
        logic       g_n;
        logic       p_n;
        logic [3:0] lines;
    } state_t;

    state_t s_q;
    state_t s_d;

    // Microinstruction and operands onto the link
    assign lnk.instr = s_q.instr;
    assign lnk.a_sel = s_q.a_sel;
    assign lnk.b_sel = s_q.b_sel;
    assign lnk.d     = s_q.d;
    assign lnk.cin   = s_q.cin;
    assign lnk.oe_n  = s_q.oe_n;

    // MSB lines fed only on a down shift, LSB lines only on an up shift
    assign lnk.q3_far_o    = s_q.shift_in[3];
    assign lnk.q3_far_oe   = slice_pkg::is_down(s_q.instr);
    assign lnk.stack_msb_shift_far_o  = s_q.shift_in[2];
    assign lnk.stack_msb_shift_far_oe = slice_pkg::is_down(s_q.instr);
    assign lnk.q0_far_o    = s_q.shift_in[1];
    assign lnk.q0_far_oe   = slice_pkg::is_up(s_q.instr);
    assign lnk.stack_lsb_shift_far_o  = s_q.shift_in[0];
    assign lnk.stack_lsb_shift_far_oe = slice_pkg::is_up(s_q.instr);

    // Registered answer
    assign RESULT_OUT    = s_q.result;
    assign CARRY_OUT     = s_q.cout;
    assign OVERFLOW_FLAG = s_q.overflow_flag;
    assign ZERO_FLAG     = s_q.zero;
    assign GEN_N         = s_q.g_n;
    assign PROP_N        = s_q.p_n;
    assign SHIFT_LINES   = s_q.lines;

    // Load request, capture the slice flags each enabled cycle and the result only while it is driven
    always_comb begin
        s_d = s_q;
        if (LOAD) begin
            s_d.instr    = INSTR;
            s_d.a_sel    = PORT_ONE_SELECT;
            s_d.b_sel    = PORT_TWO_SELECT;
            s_d.d        = DIRECT_OPERAND_IN;
            s_d.cin      = CARRY_IN;
            s_d.oe_n     = OUT_EN_N;
            s_d.shift_in = {HOLDREG_MSB_SHIFT_IN, STACK_MSB_SHIFT_IN, HOLDREG_LSB_SHIFT_IN, STACK_LSB_SHIFT_IN};
        end
        if (lnk.y_oe) begin
            s_d.result = lnk.y_o;
        end
        s_d.cout  = lnk.cout;
        s_d.overflow_flag   = lnk.overflow_flag;
        s_d.zero  = lnk.zero;
        s_d.g_n   = lnk.g_n;
        s_d.p_n   = lnk.p_n;
        s_d.lines = {lnk.q3, lnk.stack_msb_shift, lnk.q0, lnk.stack_lsb_shift};
        if (!CE) begin
            s_d = s_q;
        end
        if (RESET) begin
            s_d          = '0;
            s_d.instr    = slice_pkg::INSTR_RST;
            s_d.oe_n     = 1'b1;
        end
    end

    // Single state register
    always_ff @(posedge CLK) begin
        s_q <= s_d;
    end

endmodule

//--- hw/slice_link_if.sv
// Pin-level link between the four-bit slice and its controller side.
// Assumes one clock domain; resolves shared lines with a pull-up.
`timescale 1ns/1ps
interface slice_link_if;
    logic [3:0] a_sel;
    logic [3:0] b_sel;
    logic [8:0] instr;
    logic [3:0] d;
    logic       oe_n;
    logic       cin;
    logic [3:0] y_o;
    logic       y_oe;
    logic       cout;
    logic       overflow_flag;
    logic       g_n;
    logic       p_n;
    logic       zero_o;
    logic       zero_oe;
    logic       zero;
    logic       q3_dev_o, q3_dev_oe, q3_far_o, q3_far_oe, q3;
    logic       stack_msb_shift_dev_o, stack_msb_shift_dev_oe, stack_msb_shift_far_o, stack_msb_shift_far_oe, stack_msb_shift;
    logic       q0_dev_o, q0_dev_oe, q0_far_o, q0_far_oe, q0;
    logic       stack_lsb_shift_dev_o, stack_lsb_shift_dev_oe, stack_lsb_shift_far_o, stack_lsb_shift_far_oe, stack_lsb_shift;

    // Wire levels of the shared lines, pulled up when nobody drives
    assign q3   = q3_dev_oe   ? q3_dev_o   : (q3_far_oe   ? q3_far_o   : slice_pkg::PIN_IDLE);
    assign stack_msb_shift = stack_msb_shift_dev_oe ? stack_msb_shift_dev_o : (stack_msb_shift_far_oe ? stack_msb_shift_far_o : slice_pkg::PIN_IDLE);
    assign q0   = q0_dev_oe   ? q0_dev_o   : (q0_far_oe   ? q0_far_o   : slice_pkg::PIN_IDLE);
    assign stack_lsb_shift = stack_lsb_shift_dev_oe ? stack_lsb_shift_dev_o : (stack_lsb_shift_far_oe ? stack_lsb_shift_far_o : slice_pkg::PIN_IDLE);
    assign zero = zero_oe ? zero_o : slice_pkg::PIN_IDLE;

    modport device (
        input  a_sel, b_sel, instr, d, oe_n, cin, q3, stack_msb_shift, q0, stack_lsb_shift,
        output y_o, y_oe, cout, overflow_flag, g_n, p_n, zero_o, zero_oe,
        output q3_dev_o, q3_dev_oe, stack_msb_shift_dev_o, stack_msb_shift_dev_oe,
        output q0_dev_o, q0_dev_oe, stack_lsb_shift_dev_o, stack_lsb_shift_dev_oe
    );

    modport far (
        output a_sel, b_sel, instr, d, oe_n, cin,
        output q3_far_o, q3_far_oe, stack_msb_shift_far_o, stack_msb_shift_far_oe,
        output q0_far_o, q0_far_oe, stack_lsb_shift_far_o, stack_lsb_shift_far_oe,
        input  y_o, y_oe, cout, overflow_flag, g_n, p_n, zero, q3, stack_msb_shift, q0, stack_lsb_shift
    );
endinterface

//--- hw/slice_pkg.sv
// Shared constants, codes and decode helpers for the four-bit slice link.
// Assumes both ends and the link interface compile after this package.
package slice_pkg;

    // Widths and depth of the slice
    localparam int unsigned WORD_W  = 4;
    localparam int unsigned ADDR_W  = 4;
    localparam int unsigned DEPTH   = 16;
    localparam int unsigned INSTR_W = 9;
    localparam int unsigned FIELD_W = 3;

    // Field positions inside the microinstruction
    localparam int unsigned SRC_LSB  = 0;
    localparam int unsigned FUNC_LSB = 3;
    localparam int unsigned DEST_LSB = 6;

    // Reset values
    localparam logic [3:0] STACK_WORD_RST = 4'h0;
    localparam logic [3:0] HOLD_RST       = 4'h0;
    localparam logic [8:0] INSTR_RST      = 9'h040;  // Destination no-op, ADD, A/Q
    localparam logic       PIN_IDLE       = 1'b1;    // Pulled-up level of an undriven line

    // Operand source pairs (R, S)
    typedef enum logic [2:0] {
        SRC_AQ, SRC_AB, SRC_ZQ, SRC_ZB, SRC_ZA, SRC_DA, SRC_DQ, SRC_DZ
    } src_t;

    // Arithmetic and logic functions
    typedef enum logic [2:0] {
        FN_ADD, FN_SUBR, FN_SUBS, FN_OR, FN_AND, FN_NOTRS, FN_EXOR, FN_EXNOR
    } func_t;

    // Destination controls
    typedef enum logic [2:0] {
        DST_QREG, DST_NOP, DST_RAMA, DST_RAMF, DST_RAMQD, DST_RAMD, DST_RAMQU, DST_RAMU
    } dest_t;

    // Field extraction
    function automatic src_t src_of(input logic [8:0] instr);
        return src_t'(instr[SRC_LSB +: FIELD_W]);
    endfunction

    function automatic func_t func_of(input logic [8:0] instr);
        return func_t'(instr[FUNC_LSB +: FIELD_W]);
    endfunction

    function automatic dest_t dest_of(input logic [8:0] instr);
        return dest_t'(instr[DEST_LSB +: FIELD_W]);
    endfunction

    // Shift direction of a destination code
    function automatic logic is_up(input logic [8:0] instr);
        return (dest_of(instr) == DST_RAMQU) || (dest_of(instr) == DST_RAMU);
    endfunction

    function automatic logic is_down(input logic [8:0] instr);
        return (dest_of(instr) == DST_RAMQD) || (dest_of(instr) == DST_RAMD);
    endfunction

endpackage

//--- verif/alu_slice_chk.sv
// Checker for the slice link: relations between link lines at each rising edge.
// Assumes one clock, synchronous active-high reset, instantiated beside the link.
`timescale 1ns/1ps
module alu_slice_chk (
    // Clocking
    input logic       CLK,
    input logic       RESET,
    // Controller side
    input logic [8:0] instr,
    input logic [3:0] a_sel,
    input logic [3:0] b_sel,
    input logic [3:0] d,
    input logic       cin,
    input logic       oe_n,
    // Slice side
    input logic [3:0] y_o,
    input logic       y_oe,
    input logic       cout,
    input logic       overflow_flag,
    input logic       zero_oe,
    input logic       q3_dev_oe,
    input logic       stack_msb_shift_dev_oe,
    input logic       q0_dev_oe,
    input logic       stack_lsb_shift_dev_oe,
    input logic       stack_msb_shift_dev_o,
    input logic       stack_lsb_shift_dev_o
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);

    // Destination field and direct-plus-carry sums
    logic [2:0] dst;
    logic       d_add;
    logic [4:0] dsum;
    logic [3:0] lsum;
    logic [3:0] dlow;
    assign dst   = instr[8:6];
    assign d_add = (instr[5:0] == 6'h07);  // Add, direct and zero
    assign dsum  = {1'b0, d} + {4'h0, cin};
    assign lsum  = {1'b0, d[2:0]} + {3'h0, cin};
    assign dlow  = dsum[3:0];

    // Write a word, idle two cycles, read it back on the first port
    sequence s_write;
        dst == 3'h3 && d_add;
    endsequence
    sequence s_idle;
        dst == 3'h1;
    endsequence
    sequence s_read_back;
        dst == 3'h2 && a_sel == $past(b_sel, 3);
    endsequence
    property p_stack_round;
        s_write ##1 s_idle [*2] ##1 s_read_back |-> y_o == $past(dlow, 3);
    endproperty

    chk_stack_round_trip: assert property (p_stack_round)
        else $error("stack word not read back");
    chk_up_shift_drive: assert property (dst[2:1] == 2'b11 |-> q3_dev_oe && stack_msb_shift_dev_oe)
        else $error("up shift drivers off");
    chk_up_msb_value: assert property (dst[2:1] == 2'b11 |-> stack_msb_shift_dev_o == y_o[3])
        else $error("up shift msb value wrong");
    chk_msb_lines_off: assert property (dst[2:1] != 2'b11 |-> !q3_dev_oe && !stack_msb_shift_dev_oe)
        else $error("msb shift drivers on");
    chk_lsb_line_drive: assert property (q0_dev_oe == (dst[2:1] == 2'b10) && stack_lsb_shift_dev_oe == q0_dev_oe)
        else $error("lsb shift enables wrong");
    chk_down_lsb_value: assert property (dst[2:1] == 2'b10 |-> stack_lsb_shift_dev_o == y_o[0])
        else $error("down shift lsb value wrong");
    chk_result_enable: assert property (y_oe == !oe_n)
        else $error("result enable wrong");
    chk_zero_detect: assert property (dst != 3'h2 |-> zero_oe == (y_o != 4'h0))
        else $error("zero line wrong");
    chk_overflow_xor: assert property (d_add |-> overflow_flag == (dsum[4] ^ lsum[3]))
        else $error("overflow wrong");
    chk_carry_sum: assert property (d_add && dst != 3'h2 |-> cout == dsum[4] && y_o == dsum[3:0])
        else $error("carry or sum wrong");
endmodule

//--- verif/four_bit_alu_slice_test.sv
// Self-checking bench: slice and controller joined by the link, model in tasks.
// Assumes package, link interface and both ends compile before this file.
`timescale 1ns/1ps
module four_bit_alu_slice_test;
    logic       clk = 1'b0;
    logic       reset = 1'b1;
    logic       ce = 1'b1;
    logic [8:0] ins = 9'h040;
    logic [3:0] asel = 4'h0, bsel = 4'h0, dd = 4'h0, shin = 4'h0;
    logic       cin = 1'b0, oen = 1'b1;
    logic [3:0] res, sl, hq;
    logic       co, ov, zf, gn, pn;
    logic [3:0] stk [16];
    int         bad_count = 0;
    int         samples_checked = 0;

    slice_link_if lnk ();
    alu_slice u_alu_slice (.lnk(lnk), .CLK(clk), .RESET(reset), .CE(ce));
    slice_controller u_slice_controller (
        .lnk(lnk), .CLK(clk), .RESET(reset), .CE(ce), .LOAD(1'b1), .INSTR(ins),
        .PORT_ONE_SELECT(asel), .PORT_TWO_SELECT(bsel), .DIRECT_OPERAND_IN(dd),
        .CARRY_IN(cin), .OUT_EN_N(oen), .HOLDREG_MSB_SHIFT_IN(shin[3]),
        .STACK_MSB_SHIFT_IN(shin[2]), .HOLDREG_LSB_SHIFT_IN(shin[1]), .STACK_LSB_SHIFT_IN(shin[0]),
        .RESULT_OUT(res), .CARRY_OUT(co), .OVERFLOW_FLAG(ov), .ZERO_FLAG(zf),
        .GEN_N(gn), .PROP_N(pn), .SHIFT_LINES(sl));
    alu_slice_chk u_alu_slice_chk (
        .CLK(clk), .RESET(reset), .instr(lnk.instr), .a_sel(lnk.a_sel), .b_sel(lnk.b_sel),
        .d(lnk.d), .cin(lnk.cin), .oe_n(lnk.oe_n), .y_o(lnk.y_o), .y_oe(lnk.y_oe),
        .cout(lnk.cout), .overflow_flag(lnk.overflow_flag), .zero_oe(lnk.zero_oe), .q3_dev_oe(lnk.q3_dev_oe),
        .stack_msb_shift_dev_oe(lnk.stack_msb_shift_dev_oe), .q0_dev_oe(lnk.q0_dev_oe), .stack_lsb_shift_dev_oe(lnk.stack_lsb_shift_dev_oe),
        .stack_msb_shift_dev_o(lnk.stack_msb_shift_dev_o), .stack_lsb_shift_dev_o(lnk.stack_lsb_shift_dev_o));

    // Clock at 40 MHz
    always #12.5 clk = ~clk;

    // Comparisons of words and flags
    task automatic cmp4(input string nm, input logic [3:0] e, input logic [3:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cmp1(input string nm, input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %b seen %b", nm, e, g);
        end
    endtask

    // One microinstruction: drive, idle, judge the captured answer, update model
    task automatic op(input logic [8:0] i, input logic [3:0] a, b, dv, input logic c, oe, input logic [3:0] sh);
        logic [3:0] r, s, x, y, f, pv, gv, lo, e;
        logic [4:0] sum;
        logic       ar;
        ar = i[5:3] < 3'h3;
        r = (i[2:0] < 3'h2) ? stk[a] : (i[2:0] > 3'h4) ? dv : 4'h0;
        case (i[2:0])
            3'h1, 3'h3: s = stk[b];
            3'h4, 3'h5: s = stk[a];
            3'h7: s = 4'h0;
            default: s = hq;
        endcase
        x = (i[5:3] == 3'h1) ? ~r : r;
        y = (i[5:3] == 3'h2) ? ~s : s;
        sum = {1'b0, x} + {1'b0, y} + {4'h0, c};
        lo = {1'b0, x[2:0]} + {1'b0, y[2:0]} + {3'h0, c};
        pv = x | y;
        gv = x & y;
        case (i[5:3])
            3'h3: f = r | s;
            3'h4: f = r & s;
            3'h5: f = ~r & s;
            3'h6: f = r ^ s;
            3'h7: f = ~(r ^ s);
            default: f = sum[3:0];
        endcase
        e = 4'hf;
        if (i[8:7] == 2'b11) e = {hq[3], f[3], sh[1:0]};
        if (i[8:7] == 2'b10) e = {sh[3:2], hq[0], f[0]};
        @(posedge clk);
        ins <= i;
        asel <= a;
        bsel <= b;
        dd <= dv;
        cin <= c;
        oen <= oe;
        shin <= sh;
        @(posedge clk);
        ins <= 9'h040;
        @(posedge clk);
        #1;
        if (!oe) cmp4("result", (i[8:6] == 3'h2) ? stk[a] : f, res);
        cmp1("drive", !oe, lnk.y_oe);
        cmp1("zero", f == 4'h0, zf);
        cmp1("carry", ar & sum[4], co);
        cmp1("overflow", ar & (sum[4] ^ lo[3]), ov);
        cmp1("gen", ~(ar & (gv[3] | pv[3] & gv[2] | &pv[3:2] & gv[1] | &pv[3:1] & gv[0])), gn);
        cmp1("prop", ~(ar & (&pv)), pn);
        cmp4("shift", e, sl);
        case (i[8:6])
            3'h0: hq = f;
            3'h2, 3'h3: stk[b] = f;
            3'h4: begin
                stk[b] = {sh[2], f[3:1]};
                hq = {sh[3], hq[3:1]};
            end
            3'h5: stk[b] = {sh[2], f[3:1]};
            3'h6: begin
                stk[b] = {f[2:0], sh[0]};
                hq = {hq[2:0], sh[1]};
            end
            3'h7: stk[b] = {f[2:0], sh[0]};
            default: ;
        endcase
    endtask

    // Preset registers, then every operand source pair
    task automatic t_sources();
        op(9'h0c7, 4'h0, 4'h2, 4'h6, 1'b0, 1'b0, 4'h0);
        op(9'h0c7, 4'h0, 4'h3, 4'h5, 1'b0, 1'b0, 4'h0);
        op(9'h007, 4'h0, 4'h0, 4'ha, 1'b0, 1'b0, 4'h0);
        for (int k = 0; k < 8; k++) op({6'h08, k[2:0]}, 4'h2, 4'h3, 4'h3, 1'b0, 1'b0, 4'h0);
    endtask

    // Every function with both carry-in levels, then a zero result
    task automatic t_funcs();
        for (int k = 0; k < 16; k++) op({3'h1, k[2:0], 3'h1}, 4'h2, 4'h3, 4'h0, k[3], 1'b0, 4'h0);
        op(9'h049, 4'h3, 4'h3, 4'h0, 1'b1, 1'b0, 4'h0);
    endtask

    // Write, read back through the first port, read during write
    task automatic t_round();
        op(9'h0c7, 4'h0, 4'h9, 4'hc, 1'b1, 1'b0, 4'h0);
        op(9'h087, 4'h9, 4'h9, 4'h1, 1'b0, 1'b0, 4'h0);
        op(9'h044, 4'h9, 4'h0, 4'h0, 1'b0, 1'b0, 4'h0);
    endtask

    // Down and up shifts with both neighbour patterns, then read back
    task automatic t_shifts();
        for (int k = 4; k < 8; k++) begin
            op({k[2:0], 6'h01}, 4'h2, 4'h3, 4'h0, 1'b0, 1'b0, 4'h5);
            op({k[2:0], 6'h01}, 4'h2, 4'h3, 4'h0, 1'b1, 1'b0, 4'ha);
            op(9'h043, 4'h0, 4'h3, 4'h0, 1'b0, 1'b0, 4'h0);
            op(9'h042, 4'h0, 4'h0, 4'h0, 1'b0, 1'b0, 4'h0);
        end
    endtask

    // Result drivers off, then on again
    task automatic t_output_off();
        op(9'h047, 4'h0, 4'h0, 4'h7, 1'b0, 1'b1, 4'h0);
        op(9'h047, 4'h0, 4'h0, 4'h8, 1'b0, 1'b0, 4'h0);
    endtask

    // Clock enable low: a write held on the request lines must not land
    task automatic t_freeze();
        @(posedge clk);
        ce <= 1'b0;
        ins <= 9'h0c7;
        bsel <= 4'h4;
        dd <= 4'h3;
        repeat (2) @(posedge clk);
        ce <= 1'b1;
        ins <= 9'h040;
        op(9'h043, 4'h0, 4'h4, 4'h0, 1'b0, 1'b0, 4'h0);
    endtask

    // Verdict and end of run
    task automatic report_and_stop();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected 163 cycles
    initial begin
        repeat (2000) @(posedge clk);
        bad_count++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        foreach (stk[k]) begin
            stk[k] = 4'h0;
        end
        hq = 4'h0;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        t_sources();
        t_funcs();
        t_round();
        t_shifts();
        t_output_off();
        t_freeze();
        report_and_stop();
    end
endmodule
